// ---- rtl/irpar_core.sv ----
// parameter registers and measurement timing for ambient/ir conversions
`timescale 1ns/1ps
`default_nettype none
module irpar_core
  import irpar_pkg::*;
#(
  parameter int SEQ_REV   = REV_A03,
  parameter int ADC_DIV   = ADC_CYC,
  parameter int INTEG_LEN = INTEG_CLKS
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [7:0]         reg_rdata_q,
  input  wire logic               meas_start,
  input  wire logic               meas_ir,
  input  wire logic               raw_valid,
  input  wire logic signed [16:0] raw_data,
  input  wire logic               raw_ovr,
  output var  logic               busy_q,
  output var  logic               adc_integ_q,
  output var  logic               adc_tick_q,
  output var  logic [7:0]         adc_div_q,
  output var  logic               high_range_q,
  output var  irpar_pkg::irpar_res_t res_q,
  output var  logic               res_valid_q
);
  import irpar_pkg::*;

  localparam bit          IS_A03 = (SEQ_REV >= REV_A03);
  localparam logic [15:0] PRE_MAX = 16'(ADC_DIV - 1);
  localparam logic [9:0]  INT_MAX = 10'(INTEG_LEN - 1);

  logic [7:0]   off_q, ledrec_q, irrec_q, irrange_q, visrange_q;
  logic [2:0]   irgain_q, visgain_q;
  irpar_state_t state_q, state_d;
  irpar_meas_t  meas_q, meas_d;
  logic [15:0]  pre_q;
  logic [6:0]   div_q, div_mask;
  logic [9:0]   cnt_q;
  logic         dtick;
  logic [15:0]  off_val;
  logic [17:0]  sum;

  // register writes; reserved gain bits are not stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      off_q      <= OFF_RST;
      ledrec_q   <= LEDREC_RST;
      irrec_q    <= IRREC_RST;
      irgain_q   <= IRGAIN_RST[2:0];
      irrange_q  <= IRRANGE_RST;
      visgain_q  <= VISGAIN_RST[2:0];
      visrange_q <= VISRANGE_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_ADDR:      off_q      <= reg_wdata;
        LEDREC_ADDR:   ledrec_q   <= reg_wdata;
        IRREC_ADDR:    irrec_q    <= reg_wdata;
        IRGAIN_ADDR:   irgain_q   <= reg_wdata[2:0];
        IRRANGE_ADDR:  irrange_q  <= reg_wdata;
        VISGAIN_ADDR:  visgain_q  <= reg_wdata[2:0];
        VISRANGE_ADDR: visrange_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFF_ADDR:      reg_rdata_q <= off_q;
        LEDREC_ADDR:   reg_rdata_q <= ledrec_q;
        IRREC_ADDR:    reg_rdata_q <= irrec_q;
        IRGAIN_ADDR:   reg_rdata_q <= {5'h00, irgain_q};
        IRRANGE_ADDR:  reg_rdata_q <= irrange_q;
        VISGAIN_ADDR:  reg_rdata_q <= {5'h00, visgain_q};
        VISRANGE_ADDR: reg_rdata_q <= visrange_q;
        STAT_ADDR:     reg_rdata_q <= {6'h00, state_q};
        default:       reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // gain, range and recovery snapshot at start so writes to them cannot tear a measurement; the offset is read live
  always_comb begin
    meas_d    = '0;
    meas_d.ir = meas_ir;
    if (meas_ir && IS_A03) begin
      meas_d.gain       = irgain_q;
      meas_d.high_range = irrange_q[RANGE_BIT];
      meas_d.rec        = irrec_q[REC_LSB +: 3];
    end else begin
      meas_d.gain       = visgain_q;
      meas_d.high_range = visrange_q[RANGE_BIT];
      meas_d.rec        = 3'h0;
    end
  end

  // adc clock prescaler then gain divider; both restart with each start
  assign div_mask = 7'((8'h01 << meas_q.gain) - 8'h01);
  assign dtick    = (pre_q == PRE_MAX) && (div_q == div_mask);

  always_ff @(posedge clk) begin
    if (!rst_n || state_q == ST_IDLE) begin
      pre_q <= 16'h0000;
      div_q <= 7'h00;
    end else if (pre_q == PRE_MAX) begin
      pre_q <= 16'h0000;
      div_q <= (div_q == div_mask) ? 7'h00 : 7'(div_q + 7'h01);
    end else begin
      pre_q <= 16'(pre_q + 16'h0001);
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (meas_start) state_d = ST_REC;
      ST_REC:  if (dtick && cnt_q == 10'h000) state_d = ST_INT;
      ST_INT:  if (dtick && cnt_q == 10'h000) state_d = ST_WAIT;
      ST_WAIT: if (raw_valid) state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      meas_q  <= '0;
      cnt_q   <= 10'h000;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && meas_start) begin
        meas_q <= meas_d;
        cnt_q  <= 10'(irpar_rec_clks(meas_d.rec) - 10'h001);
      end else if (dtick) begin
        if (cnt_q != 10'h000) begin
          cnt_q <= 10'(cnt_q - 10'h001);
        end else begin
          cnt_q <= INT_MAX;
        end
      end
    end
  end

  // converter-facing controls
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q       <= 1'b0;
      adc_integ_q  <= 1'b0;
      adc_tick_q   <= 1'b0;
      adc_div_q    <= 8'h01;
      high_range_q <= 1'b0;
    end else begin
      busy_q       <= (state_d != ST_IDLE);
      adc_integ_q  <= (state_d == ST_INT);
      adc_tick_q   <= dtick && state_q == ST_INT;
      adc_div_q    <= 8'h01 << meas_q.gain;
      high_range_q <= meas_q.high_range;
    end
  end

  // offset add with clamp; only the overrange flag may produce 0xffff
  assign off_val = irpar_expand(off_q);
  assign sum = {raw_data[16], raw_data} + {2'b00, off_val};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_q       <= '0;
      res_valid_q <= 1'b0;
    end else begin
      res_valid_q <= (state_q == ST_WAIT) && raw_valid;
      if (state_q == ST_WAIT && raw_valid) begin
        res_q.ir  <= meas_q.ir;
        res_q.ovr <= raw_ovr;
        if (raw_ovr) begin
          res_q.data <= OVR_CODE;
        end else if (sum[17]) begin
          res_q.data <= 16'h0000;
        end else if (sum[16:0] >= {1'b0, OVR_CODE}) begin
          res_q.data <= MAX_CODE;
        end else begin
          res_q.data <= sum[15:0];
        end
      end
    end
  end

  // assertion helpers: cycles spent in the current state
  logic [23:0] cyc_q;
  always_ff @(posedge clk) begin
    if (!rst_n || state_d != state_q) begin
      cyc_q <= 24'h00_0000;
    end else begin
      cyc_q <= 24'(cyc_q + 24'h00_0001);
    end
  end

  a_ovr_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    res_valid_q && !res_q.ovr |-> res_q.data != OVR_CODE)
    else $error("ordinary result reported as overrange code");

  a_ovr_passes: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_WAIT && raw_valid && raw_ovr
    |=> res_valid_q && res_q.data == OVR_CODE)
    else $error("overrange not reported as 0xffff");

  a_offset_added: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_WAIT && raw_valid && !raw_ovr && raw_data == 17'sd0
    |=> res_q.data == (($past(off_val) == OVR_CODE) ? MAX_CODE
                                                    : $past(off_val)))
    else $error("zero result does not carry the offset");

  a_offset_decode: assert property (@(posedge clk) disable iff (!rst_n)
    (off_q == 8'h60 |-> off_val == 16'h0040) and
    (off_q == 8'h70 |-> off_val == 16'h0080) and
    (off_q == 8'h80 |-> off_val == 16'h0100))
    else $error("offset byte decoded to wrong code count");

  a_rec_length: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_REC && state_d == ST_INT |-> 32'(cyc_q) + 1 ==
    32'(irpar_rec_clks(meas_q.rec)) * ADC_DIV * (1 << meas_q.gain))
    else $error("recovery period length wrong");

  a_integ_length: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_INT && state_d == ST_WAIT |->
    32'(cyc_q) + 1 == INTEG_LEN * ADC_DIV * (1 << meas_q.gain))
    else $error("integration length not scaled by gain");

  a_div_value: assert property (@(posedge clk) disable iff (!rst_n)
    busy_q && $stable(meas_q) |=> adc_div_q == 8'h01 << meas_q.gain)
    else $error("adc divisor does not match gain exponent");

  a_range_sel: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_IDLE && meas_start && meas_ir && IS_A03
    |=> meas_q.high_range == $past(irrange_q[RANGE_BIT]))
    else $error("ir_high_range_select bit not applied");

  a_legacy_gain: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_IDLE && meas_start && !IS_A03
    |=> meas_q.gain == $past(visgain_q) && meas_q.rec == 3'h0)
    else $error("legacy revision ignores visible settings");

  c_ir_done: cover property (@(posedge clk) disable iff (!rst_n)
    res_valid_q && res_q.ir && !res_q.ovr);
  c_ovr: cover property (@(posedge clk) disable iff (!rst_n)
    res_valid_q && res_q.ovr);
  c_vis_done: cover property (@(posedge clk) disable iff (!rst_n)
    res_valid_q && !res_q.ir);
  c_high_gain: cover property (@(posedge clk) disable iff (!rst_n)
    adc_integ_q && meas_q.gain == 3'h7);
endmodule : irpar_core
`default_nettype wire

// ---- include/irpar_pkg.sv ----
// shared constants, types and decode functions of the ir parameter block
package irpar_pkg;
  // register offsets; vis gain and status are local picks
  localparam logic [7:0] OFF_ADDR      = 8'h1a;
  localparam logic [7:0] LEDREC_ADDR   = 8'h1c;
  localparam logic [7:0] IRREC_ADDR    = 8'h1d;
  localparam logic [7:0] IRGAIN_ADDR   = 8'h1e;
  localparam logic [7:0] IRRANGE_ADDR  = 8'h1f;
  localparam logic [7:0] VISGAIN_ADDR  = 8'h11;
  localparam logic [7:0] VISRANGE_ADDR = 8'h12;
  localparam logic [7:0] STAT_ADDR     = 8'h20;
  // reset values
  localparam logic [7:0] OFF_RST       = 8'h80;
  localparam logic [7:0] LEDREC_RST    = 8'h00;
  localparam logic [7:0] IRREC_RST     = 8'h70;
  localparam logic [7:0] IRGAIN_RST    = 8'h00;
  localparam logic [7:0] IRRANGE_RST   = 8'h00;
  localparam logic [7:0] VISGAIN_RST   = 8'h00;
  localparam logic [7:0] VISRANGE_RST  = 8'h00;
  // field positions
  localparam int RANGE_BIT = 5;
  localparam int REC_LSB   = 4;
  localparam int GAIN_W    = 3;
  // timing
  localparam int CLK_NS      = 10;
  localparam int ADC_CLK_NS  = 50;
  localparam int ADC_CYC     = (ADC_CLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int INTEG_CLKS  = 16;
  localparam int REV_A03     = 3;
  // result codes
  localparam logic [15:0] OVR_CODE = 16'hffff;
  localparam logic [15:0] MAX_CODE = 16'hfffe;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REC,
    ST_INT,
    ST_WAIT
  } irpar_state_t;

  typedef struct packed {
    logic [2:0] gain;
    logic       high_range;
    logic [2:0] rec;
    logic       ir;
  } irpar_meas_t;

  typedef struct packed {
    logic [15:0] data;
    logic        ovr;
    logic        ir;
  } irpar_res_t;

  // compressed byte: 1.mmmm times 2^eeee, saturated to 0xffff above 16 bits
  function automatic logic [15:0] irpar_expand(input logic [7:0] c);
    logic [35:0] v;
    v = {31'h0000_0000, 1'b1, c[3:0]} << c[7:4];
    irpar_expand = (|v[35:20]) ? 16'hffff : v[19:4];
  endfunction : irpar_expand

  // recovery code to adc clocks
  function automatic logic [9:0] irpar_rec_clks(input logic [2:0] n);
    logic [10:0] v;
    v = 11'h001 << (4'(n) + 4'h2);
    irpar_rec_clks = (n == 3'h0) ? 10'h001 : 10'(v - 11'h001);
  endfunction : irpar_rec_clks
endpackage : irpar_pkg

// ---- tb/irpar_adc_model.sv ----
// behavioural converter that hands raw difference results to the block
`timescale 1ns/1ps
`default_nettype none
module irpar_adc_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               integ,
  input  wire logic signed [16:0] value,
  input  wire logic               over,
  input  wire logic [3:0]         delay,
  output var  logic               raw_valid,
  output var  logic signed [16:0] raw_data,
  output var  logic               raw_ovr
);
  logic       integ_q;
  logic       pend_q;
  logic [3:0] wait_q;
  // off the strobe the lines carry the inverse, so a stale value never matches
  assign raw_data = raw_valid ? value : ~value;
  assign raw_ovr  = raw_valid ? over : ~over;
  always_ff @(posedge clk) begin
    integ_q   <= integ;
    raw_valid <= 1'b0;
    if (!rst_n) begin
      pend_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (integ_q && !integ) begin
      pend_q <= 1'b1;
      wait_q <= delay;
    end else if (pend_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (pend_q) begin
      pend_q    <= 1'b0;
      raw_valid <= 1'b1;
    end
  end
endmodule : irpar_adc_model
`default_nettype wire

// ---- tb/tb.sv ----
// register and measurement bench of the ir parameter block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irpar_pkg::*;
  localparam int DIV  = 5;
  localparam int ILEN = 2;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [7:0]         wdata = 8'h00;
  logic               wr_s = 1'b0;
  logic               rd_s = 1'b0;
  logic               start = 1'b0;
  logic               ir = 1'b0;
  logic signed [16:0] val = 17'sh0_0000;
  logic               over = 1'b0;
  logic [3:0]         dly = 4'h0;
  logic [7:0]         rdata, adiv, adiv2, v;
  logic               raw_valid, raw_ovr, busy, integ, tick, hr, hr2, rv;
  logic signed [16:0] raw_data;
  irpar_res_t         res;
  logic [7:0]         old_div;
  logic               old_hr;
  logic               vis_sel = 1'b0;
  int                 error_cnt = 0;
  int                 n_checks = 0;
  always #5 clk = ~clk;
  irpar_adc_model adc (.clk(clk), .rst_n(rst_n), .integ(integ), .value(val),
    .over(over), .delay(dly), .raw_valid(raw_valid), .raw_data(raw_data),
    .raw_ovr(raw_ovr));
  irpar_core #(.ADC_DIV(DIV), .INTEG_LEN(ILEN)) dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata_q(rdata), .meas_start(start), .meas_ir(ir),
    .raw_valid(raw_valid), .raw_data(raw_data), .raw_ovr(raw_ovr),
    .busy_q(busy), .adc_integ_q(integ), .adc_tick_q(tick), .adc_div_q(adiv),
    .high_range_q(hr), .res_q(res), .res_valid_q(rv));
  // older sequencer: ir measurements follow the visible settings
  irpar_core #(.SEQ_REV(2), .ADC_DIV(DIV), .INTEG_LEN(ILEN)) dut_old (
    .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata_q(), .meas_start(start),
    .meas_ir(ir), .raw_valid(raw_valid), .raw_data(raw_data),
    .raw_ovr(raw_ovr), .busy_q(), .adc_integ_q(), .adc_tick_q(),
    .adc_div_q(adiv2), .high_range_q(hr2), .res_q(), .res_valid_q());

  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic step(inout int n);
    n++;
    @(posedge clk);
    #1;
    if (n > 9000) begin
      error_cnt++;
      final_report();
    end
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    output logic [7:0] got);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 got = rdata;
    chk(got, e);
  endtask : rd

  function automatic int rclk(input int c);
    return (c == 0) ? 1 : (1 << (c + 2)) - 1;
  endfunction : rclk

  task automatic meas(input int rc, input int g, input logic h,
                      input logic [15:0] ed, input logic eo);
    int n;
    int t;
    wr(IRREC_ADDR, {1'b0, 3'(rc), 4'h0});
    wr(IRGAIN_ADDR, {5'h00, 3'(g)});
    @(posedge clk);
    start <= 1'b1;
    ir    <= ~vis_sel;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    // divisor and range follow the snapshot one cycle after busy rises
    step(n);
    old_div = adiv2;
    old_hr = hr2;
    chk(adiv, 1 << g);
    chk(hr, h);
    while (busy === 1'b1 && integ !== 1'b1) step(n);
    chk(n, rclk(rc) * DIV * (1 << g));
    n = 0;
    t = 0;
    while (integ === 1'b1) begin
      if (tick === 1'b1) t++;
      step(n);
    end
    // the last tick is registered into the first wait cycle
    if (tick === 1'b1) t++;
    chk(n, ILEN * DIV * (1 << g));
    chk(t, ILEN);
    n = 0;
    while (rv !== 1'b1) step(n);
    chk(res.data, ed);
    chk({res.ovr, res.ir}, {eo, ~vis_sel});
  endtask : meas

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFF_ADDR, 8'h80, v);
    rd(LEDREC_ADDR, 8'h00, v);
    rd(IRREC_ADDR, 8'h70, v);
    rd(IRGAIN_ADDR, 8'h00, v);
    rd(IRRANGE_ADDR, 8'h00, v);
    rd(STAT_ADDR, 8'h00, v);
    wr(IRGAIN_ADDR, 8'hff);
    rd(IRGAIN_ADDR, 8'h07, v);
    wr(8'h00, 8'h5a);
    rd(8'h00, 8'h00, v);
    meas(0, 0, 1'b0, 16'h0100, 1'b0);
    wr(OFF_ADDR, 8'h60);
    meas(0, 0, 1'b0, 16'h0040, 1'b0);
    wr(OFF_ADDR, 8'h70);
    meas(0, 0, 1'b0, 16'h0080, 1'b0);
    wr(OFF_ADDR, 8'h80);
    val <= 17'sh0_0005;
    for (int c = 0; c < 8; c++) meas(c, 0, 1'b0, 16'h0105, 1'b0);
    dly = 4'h9;
    for (int g = 4; g < 8; g++) meas(1, g, 1'b0, 16'h0105, 1'b0);
    val = 17'sh0_feff;
    meas(0, 0, 1'b0, 16'hfffe, 1'b0);
    val = -17'sd300;
    meas(0, 1, 1'b0, 16'h0000, 1'b0);
    over = 1'b1;
    meas(0, 0, 1'b0, 16'hffff, 1'b1);
    over = 1'b0;
    val = 17'sh0_0000;
    rd(IRRANGE_ADDR, 8'h00, v);
    wr(IRRANGE_ADDR, v | 8'h20);
    rd(IRRANGE_ADDR, v | 8'h20, v);
    wr(VISGAIN_ADDR, 8'h03);
    meas(2, 5, 1'b1, 16'h0100, 1'b0);
    chk({old_div, old_hr}, {8'h08, 1'b0});
    vis_sel = 1'b1;
    meas(0, 3, 1'b0, 16'h0100, 1'b0);
    final_report();
  end
endmodule : tb
`default_nettype wire
